// *** hw/sri_defines.svh ***
// Opcodes, status codes, flag positions and reset values of the calc unit.
`ifndef SRI_DEFINES_SVH
`define SRI_DEFINES_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define SRI_OP_RETURN      8'h26
`define SRI_OP_CALC_VV     8'h28
`define SRI_OP_CALC_VA     8'h29

// ----------------------------------------------------------------------
// Reply status codes
// ----------------------------------------------------------------------
`define SRI_STATUS_OK      8'h64
`define SRI_STATUS_BAD_CMD 8'h02
`define SRI_STATUS_BAD_TYP 8'h03

// ----------------------------------------------------------------------
// Flag bit positions, last type code and reset values
// ----------------------------------------------------------------------
`define SRI_FLAG_ZERO      0
`define SRI_FLAG_LESS      1
`define SRI_TYPE_LAST      8'h0B
`define SRI_WORD_RESET     32'h0000_0000
`define SRI_BYTE_RESET     8'h00

`endif

// *** hw/sri_pkg.sv ***
// Types shared by the calc unit and its variable memory.
package sri_pkg;

  typedef logic [31:0] sri_word_type;

  typedef enum logic [7:0] {
    CALC_ADD  = 8'h00,
    CALC_SUB  = 8'h01,
    CALC_MUL  = 8'h02,
    CALC_DIV  = 8'h03,
    CALC_MOD  = 8'h04,
    CALC_AND  = 8'h05,
    CALC_OR   = 8'h06,
    CALC_XOR  = 8'h07,
    CALC_NOT  = 8'h08,
    CALC_LOAD = 8'h09,
    CALC_SWAP = 8'h0A,
    CALC_COMP = 8'h0B
  } sri_calc_op_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_RD_A = 5'b0_0010,
    ST_RD_B = 5'b0_0100,
    ST_EXEC = 5'b0_1000,
    ST_WR_B = 5'b1_0000
  } sri_state_type;

endpackage

// *** hw/sri_var_mem.sv ***
// User variable array, 256 words, one port, registered read data.
`include "sri_defines.svh"
module sri_var_mem (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           addr,
  input  wire logic                 we,
  input  wire sri_pkg::sri_word_type wdata,
  output sri_pkg::sri_word_type      rdata_q
);
  import sri_pkg::*;

  sri_word_type mem_q [256];
  sri_word_type rdata_d;

  always_comb begin
    rdata_d = mem_q[addr];
  end

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= `SRI_WORD_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

// *** hw/sri_calc_unit.sv ***
// Handler return and user variable calculation commands of the interpreter.
`include "sri_defines.svh"

// Behaviour
// - Code 38 ends handler; other fields ignored.
// - Return restores accumulator, X, flags, counter.
// - Code 40 combines two variables into first.
// - First index bank field, second value field.
// - Type codes 0..11 select the operation.
// - Types 8,9,10: invert, load, swap second.
// - Code 41 updates bank-indexed variable with accumulator.
// - Same twelve types, accumulator as second operand.
// - Direct mode replies status 100 on success.
module sri_calc_unit (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic [7:0]            cmd_opcode,
  input  wire logic [7:0]            cmd_type,
  input  wire logic [7:0]            cmd_bank,
  input  wire sri_pkg::sri_word_type cmd_value,
  output logic                       rsp_valid_q,
  output logic [7:0]                 rsp_status_q,
  output logic [7:0]                 rsp_opcode_q,
  output sri_pkg::sri_word_type      rsp_value_q,
  input  wire sri_pkg::sri_word_type accu_in,
  input  wire sri_pkg::sri_word_type saved_accu,
  input  wire sri_pkg::sri_word_type saved_xreg,
  input  wire logic [7:0]            saved_flags,
  input  wire sri_pkg::sri_word_type saved_pc,
  output logic                       ctx_wr_q,
  output logic                       accu_wr_q,
  output sri_pkg::sri_word_type      accu_out_q,
  output sri_pkg::sri_word_type      xreg_out_q,
  output logic                       flags_wr_q,
  output logic [7:0]                 flags_out_q,
  output sri_pkg::sri_word_type      pc_out_q,
  output logic                       handler_done_q
);
  import sri_pkg::*;

  // ----------------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------------
  // Division by zero leaves the destination at its old value.
  function automatic sri_word_type calc(input logic [7:0]   op,
                                        input sri_word_type a,
                                        input sri_word_type b);
    sri_word_type r;
    r = a;
    case (sri_calc_op_type'(op))
      CALC_ADD:  r = a + b;
      CALC_SUB:  r = a - b;
      CALC_MUL:  r = a * b;
      CALC_DIV:  r = (b == '0) ? a : sri_word_type'($signed(a) / $signed(b));
      CALC_MOD:  r = (b == '0) ? a : sri_word_type'($signed(a) % $signed(b));
      CALC_AND:  r = a & b;
      CALC_OR:   r = a | b;
      CALC_XOR:  r = a ^ b;
      CALC_NOT:  r = ~b;
      CALC_LOAD: r = b;
      CALC_SWAP: r = b;
      default:   r = a;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  sri_state_type state_q, state_d;
  logic [7:0]    op_q, op_d, type_q, type_d, bank_q, bank_d, idx_q, idx_d;
  sri_word_type  opa_q, opa_d;
  logic          rsp_valid_d, ctx_wr_d, accu_wr_d, flags_wr_d, handler_done_d;
  logic [7:0]    rsp_status_d, rsp_opcode_d, flags_out_d;
  sri_word_type  rsp_value_d, accu_out_d, xreg_out_d, pc_out_d;
  logic [7:0]    mem_addr;
  sri_word_type  mem_wdata, mem_rdata, opb, result;
  logic          cmd_accept, is_vv, mem_we;

  assign cmd_ready  = (state_q == ST_IDLE);
  assign cmd_accept = cmd_valid && cmd_ready;
  assign is_vv      = (op_q == `SRI_OP_CALC_VV);
  assign opb        = is_vv ? mem_rdata : accu_in;
  assign result     = calc(type_q, opa_q, opb);

  sri_var_mem u_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .addr     (mem_addr),
    .we       (mem_we),
    .wdata    (mem_wdata),
    .rdata_q  (mem_rdata)
  );

  always_comb begin
    state_d        = state_q;
    op_d           = op_q;
    type_d         = type_q;
    bank_d         = bank_q;
    idx_d          = idx_q;
    opa_d          = opa_q;
    rsp_valid_d    = 1'b0;
    rsp_status_d   = rsp_status_q;
    rsp_opcode_d   = rsp_opcode_q;
    rsp_value_d    = rsp_value_q;
    ctx_wr_d       = 1'b0;
    accu_wr_d      = 1'b0;
    flags_wr_d     = 1'b0;
    handler_done_d = 1'b0;
    accu_out_d     = accu_out_q;
    xreg_out_d     = xreg_out_q;
    flags_out_d    = flags_out_q;
    pc_out_d       = pc_out_q;
    mem_addr       = bank_q;
    mem_we         = 1'b0;
    mem_wdata      = result;
    case (state_q)
      ST_IDLE: begin
        if (cmd_accept) begin
          op_d         = cmd_opcode;
          type_d       = cmd_type;
          bank_d       = cmd_bank;
          idx_d        = cmd_value[7:0];
          rsp_opcode_d = cmd_opcode;
          rsp_value_d  = `SRI_WORD_RESET;
          if (cmd_opcode == `SRI_OP_RETURN) begin
            // Type, bank and value are not looked at.
            rsp_valid_d    = 1'b1;
            rsp_status_d   = `SRI_STATUS_OK;
            handler_done_d = 1'b1;
            ctx_wr_d       = 1'b1;
            accu_out_d     = saved_accu;
            xreg_out_d     = saved_xreg;
            flags_out_d    = saved_flags;
            pc_out_d       = saved_pc;
          end else if (cmd_opcode != `SRI_OP_CALC_VV &&
                       cmd_opcode != `SRI_OP_CALC_VA) begin
            rsp_valid_d  = 1'b1;
            rsp_status_d = `SRI_STATUS_BAD_CMD;
          end else if (cmd_type > `SRI_TYPE_LAST) begin
            rsp_valid_d  = 1'b1;
            rsp_status_d = `SRI_STATUS_BAD_TYP;
          end else begin
            state_d = ST_RD_A;
          end
        end
      end
      ST_RD_A: begin
        state_d = ST_RD_B;
      end
      ST_RD_B: begin
        opa_d    = mem_rdata;
        mem_addr = idx_q;
        state_d  = ST_EXEC;
      end
      ST_EXEC: begin
        mem_we       = (type_q != CALC_COMP);
        rsp_status_d = `SRI_STATUS_OK;
        rsp_value_d  = opb;
        if (type_q == CALC_COMP) begin
          flags_wr_d                  = 1'b1;
          flags_out_d[`SRI_FLAG_ZERO] = (opa_q == opb);
          flags_out_d[`SRI_FLAG_LESS] = ($signed(opa_q) < $signed(opb));
        end
        if (type_q == CALC_SWAP && is_vv) begin
          state_d = ST_WR_B;
        end else begin
          if (type_q == CALC_SWAP) begin
            accu_wr_d  = 1'b1;
            accu_out_d = opa_q;
          end
          rsp_valid_d = 1'b1;
          state_d     = ST_IDLE;
        end
      end
      ST_WR_B: begin
        mem_addr    = idx_q;
        mem_we      = 1'b1;
        mem_wdata   = opa_q;
        rsp_valid_d = 1'b1;
        state_d     = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q        <= ST_IDLE;
      op_q           <= `SRI_BYTE_RESET;
      type_q         <= `SRI_BYTE_RESET;
      bank_q         <= `SRI_BYTE_RESET;
      idx_q          <= `SRI_BYTE_RESET;
      opa_q          <= `SRI_WORD_RESET;
      rsp_valid_q    <= 1'b0;
      rsp_status_q   <= `SRI_BYTE_RESET;
      rsp_opcode_q   <= `SRI_BYTE_RESET;
      rsp_value_q    <= `SRI_WORD_RESET;
      ctx_wr_q       <= 1'b0;
      accu_wr_q      <= 1'b0;
      flags_wr_q     <= 1'b0;
      handler_done_q <= 1'b0;
      accu_out_q     <= `SRI_WORD_RESET;
      xreg_out_q     <= `SRI_WORD_RESET;
      flags_out_q    <= `SRI_BYTE_RESET;
      pc_out_q       <= `SRI_WORD_RESET;
    end else begin
      state_q        <= state_d;
      op_q           <= op_d;
      type_q         <= type_d;
      bank_q         <= bank_d;
      idx_q          <= idx_d;
      opa_q          <= opa_d;
      rsp_valid_q    <= rsp_valid_d;
      rsp_status_q   <= rsp_status_d;
      rsp_opcode_q   <= rsp_opcode_d;
      rsp_value_q    <= rsp_value_d;
      ctx_wr_q       <= ctx_wr_d;
      accu_wr_q      <= accu_wr_d;
      flags_wr_q     <= flags_wr_d;
      handler_done_q <= handler_done_d;
      accu_out_q     <= accu_out_d;
      xreg_out_q     <= xreg_out_d;
      flags_out_q    <= flags_out_d;
      pc_out_q       <= pc_out_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_return_restore:
    assert property (@(posedge core_clk) disable iff (rst)
      cmd_accept && cmd_opcode == `SRI_OP_RETURN |=> ctx_wr_q &&
      accu_out_q == $past(saved_accu) && xreg_out_q == $past(saved_xreg) &&
      flags_out_q == $past(saved_flags) && pc_out_q == $past(saved_pc))
    else $error("Return did not restore the saved context.");
  a_return_reply:
    assert property (@(posedge core_clk) disable iff (rst)
      cmd_accept && cmd_opcode == `SRI_OP_RETURN |=>
      rsp_valid_q && handler_done_q && rsp_status_q == `SRI_STATUS_OK)
    else $error("Return did not end the handler with an OK reply.");
  a_vv_no_accu:
    assert property (@(posedge core_clk) disable iff (rst)
      cmd_accept && cmd_opcode == `SRI_OP_CALC_VV |=>
      (!accu_wr_q && !ctx_wr_q) [*4] ##1 !accu_wr_q)
    else $error("Two-variable calculation touched the accumulator.");
  a_second_index:
    assert property (@(posedge core_clk) disable iff (rst)
      state_q == ST_RD_B |-> mem_addr == idx_q && $past(mem_addr) == bank_q)
    else $error("Variable indices not taken from bank and value.");
  a_calc_reply_time:
    assert property (@(posedge core_clk) disable iff (rst)
      cmd_accept && cmd_type <= `SRI_TYPE_LAST &&
      (cmd_opcode == `SRI_OP_CALC_VV || cmd_opcode == `SRI_OP_CALC_VA)
      |-> ##[4:5] (rsp_valid_q && rsp_status_q == `SRI_STATUS_OK))
    else $error("Calculation reply missing or not OK.");
  a_compare_keep:
    assert property (@(posedge core_clk) disable iff (rst)
      state_q == ST_EXEC && type_q == CALC_COMP |-> !mem_we ##1
      (flags_wr_q && flags_out_q[`SRI_FLAG_ZERO] == $past(opa_q == opb)))
    else $error("Compare changed a variable or left the flags.");
  a_not_value:
    assert property (@(posedge core_clk) disable iff (rst)
      state_q == ST_EXEC && type_q == CALC_NOT |-> mem_we &&
      mem_wdata == ~opb && mem_addr == bank_q)
    else $error("Invert did not store the inverted operand.");

  a_va_sub:
    assert property (@(posedge core_clk) disable iff (rst)
      state_q == ST_EXEC && !is_vv && type_q == CALC_SUB |->
      mem_wdata == opa_q - accu_in)
    else $error("Subtract did not remove the accumulator.");

  a_va_swap:
    assert property (@(posedge core_clk) disable iff (rst)
      state_q == ST_EXEC && !is_vv && type_q == CALC_SWAP |=>
      accu_wr_q && accu_out_q == $past(opa_q))
    else $error("Swap did not move the variable to the accumulator.");

  a_vv_swap:
    assert property (@(posedge core_clk) disable iff (rst)
      state_q == ST_EXEC && is_vv && type_q == CALC_SWAP |=>
      mem_we && mem_addr == idx_q && mem_wdata == $past(opa_q))
    else $error("Swap did not write the second variable.");

endmodule

// *** sim/sri_host_model.sv ***
// Interpreter context around the calc unit: accumulator, X, flags, counter.
module sri_host_model (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  set_en,
  input  wire sri_pkg::sri_word_type set_val,
  input  wire logic                  enter,
  input  wire logic                  ctx_wr_q,
  input  wire logic                  accu_wr_q,
  input  wire logic                  flags_wr_q,
  input  wire sri_pkg::sri_word_type accu_out_q,
  input  wire sri_pkg::sri_word_type xreg_out_q,
  input  wire logic [7:0]            flags_out_q,
  input  wire sri_pkg::sri_word_type pc_out_q,
  output sri_pkg::sri_word_type      accu_q,
  output sri_pkg::sri_word_type      saved_accu,
  output sri_pkg::sri_word_type      saved_xreg,
  output logic [7:0]                 saved_flags,
  output sri_pkg::sri_word_type      saved_pc
);
  timeunit 1ns;
  timeprecision 100ps;
  import sri_pkg::*;
  sri_word_type xreg_q;
  sri_word_type pc_q;
  logic [7:0]   flags_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accu_q <= 32'h0000_0000;
      xreg_q <= 32'h0000_0777;
      flags_q <= 8'hA4;
      pc_q <= 32'h0000_0000;
      saved_accu <= 32'h0000_0000;
      saved_xreg <= 32'h0000_0000;
      saved_flags <= 8'h00;
      saved_pc <= 32'h0000_0000;
    end else begin
      pc_q <= pc_q + 32'h0000_0001;
      if (set_en) accu_q <= set_val;
      if (accu_wr_q) accu_q <= accu_out_q;
      if (flags_wr_q) flags_q <= flags_out_q;
      // Handler entry saves the context and jumps to the vector.
      if (enter) begin
        saved_accu <= accu_q;
        saved_xreg <= xreg_q;
        saved_flags <= flags_q;
        saved_pc <= pc_q;
        xreg_q <= ~xreg_q;
        pc_q <= 32'h0000_0040;
      end
      if (ctx_wr_q) begin
        accu_q <= accu_out_q;
        xreg_q <= xreg_out_q;
        flags_q <= flags_out_q;
        pc_q <= pc_out_q;
      end
    end
  end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the handler return and variable calc unit.
`include "sri_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sri_pkg::*;
  logic         core_clk, rst, cmd_valid, cmd_ready, rsp_valid_q;
  logic [7:0]   cmd_opcode, cmd_type, cmd_bank, rsp_status_q, rsp_opcode_q;
  sri_word_type cmd_value, rsp_value_q, accu_in, saved_accu, saved_xreg;
  sri_word_type saved_pc, accu_out_q, xreg_out_q, pc_out_q, set_val;
  logic [7:0]   saved_flags, flags_out_q;
  logic         ctx_wr_q, accu_wr_q, flags_wr_q, handler_done_q;
  logic         set_en, enter;
  int           num_errors = 0;
  int           compares = 0;
  localparam sri_word_type PA [3] = '{32'h0000_7A35, 32'hFFFF_FF00,
                                      32'h0000_0005};
  localparam sri_word_type PB [3] = '{32'h0000_0013, 32'h0000_0005,
                                      32'h0000_0005};

  sri_calc_unit u_dut (.core_clk(core_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value),
    .rsp_valid_q(rsp_valid_q), .rsp_status_q(rsp_status_q),
    .rsp_opcode_q(rsp_opcode_q), .rsp_value_q(rsp_value_q),
    .accu_in(accu_in), .saved_accu(saved_accu), .saved_xreg(saved_xreg),
    .saved_flags(saved_flags), .saved_pc(saved_pc), .ctx_wr_q(ctx_wr_q),
    .accu_wr_q(accu_wr_q), .accu_out_q(accu_out_q),
    .xreg_out_q(xreg_out_q), .flags_wr_q(flags_wr_q),
    .flags_out_q(flags_out_q), .pc_out_q(pc_out_q),
    .handler_done_q(handler_done_q));

  sri_host_model u_host (.core_clk(core_clk), .rst(rst), .set_en(set_en),
    .set_val(set_val), .enter(enter), .ctx_wr_q(ctx_wr_q),
    .accu_wr_q(accu_wr_q), .flags_wr_q(flags_wr_q),
    .accu_out_q(accu_out_q), .xreg_out_q(xreg_out_q),
    .flags_out_q(flags_out_q), .pc_out_q(pc_out_q), .accu_q(accu_in),
    .saved_accu(saved_accu), .saved_xreg(saved_xreg),
    .saved_flags(saved_flags), .saved_pc(saved_pc));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Offers one command, waits for the reply and checks its latency.
  task automatic issue(input logic [7:0] op, input logic [7:0] ty,
                       input logic [7:0] bk, input sri_word_type vl,
                       input int lat, input logic [7:0] st);
    int n;
    n = 0;
    cmd_opcode = op;
    cmd_type = ty;
    cmd_bank = bk;
    cmd_value = vl;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid_q !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n, lat);
    chk(rsp_status_q, st);
    chk(rsp_opcode_q, op);
  endtask

  task automatic set_accu(input sri_word_type v);
    set_val = v;
    set_en = 1'b1;
    @(posedge core_clk);
    #1;
    set_en = 1'b0;
  endtask

  task automatic wr_var(input logic [7:0] i, input sri_word_type v);
    set_accu(v);
    issue(`SRI_OP_CALC_VA, 8'h09, i, 32'h0, 3, `SRI_STATUS_OK);
  endtask

  // Compare leaves variables alone and replies with the second one.
  task automatic rd_var(input logic [7:0] i, output sri_word_type v);
    issue(`SRI_OP_CALC_VV, 8'h0B, i, {24'h0, i}, 3, `SRI_STATUS_OK);
    v = rsp_value_q;
  endtask

  function automatic sri_word_type calc(input logic [7:0] t,
                                        input sri_word_type a,
                                        input sri_word_type b);
    case (t)
      8'h00: return a + b;
      8'h01: return a - b;
      8'h02: return a * b;
      8'h03: return sri_word_type'($signed(a) / $signed(b));
      8'h04: return sri_word_type'($signed(a) % $signed(b));
      8'h05: return a & b;
      8'h06: return a | b;
      8'h07: return a ^ b;
      8'h08: return ~b;
      8'h09, 8'h0A: return b;
      default: return a;
    endcase
  endfunction

  // Every type code for one opcode, variable 0 against 255 or accumulator.
  task automatic t_ops(input logic [7:0] op);
    sri_word_type a, b, v;
    logic [7:0]   t;
    logic         vv;
    vv = (op == `SRI_OP_CALC_VV);
    for (int p = 0; p < 3; p++) begin
      a = PA[p];
      b = PB[p];
      for (int i = 0; i < 12; i++) begin
        t = 8'(i);
        wr_var(8'h00, a);
        if (vv) wr_var(8'hFF, b);
        else set_accu(b);
        issue(op, t, 8'h00, vv ? 32'h0000_00FF : 32'hFFFF_FF01,
              (vv && t == 8'h0A) ? 4 : 3,
              `SRI_STATUS_OK);
        chk(rsp_value_q, b);
        if (t == 8'h0B) begin
          chk(flags_wr_q, 1'b1);
          chk(flags_out_q[1:0], {$signed(a) < $signed(b), a == b});
        end
        if (!vv && t == 8'h0A) begin
          chk(accu_wr_q, 1'b1);
          chk(accu_out_q, a);
        end else begin
          chk(accu_wr_q, 1'b0);
        end
        rd_var(8'h00, v);
        chk(v, calc(t, a, b));
        if (vv && t == 8'h0A) begin
          rd_var(8'hFF, v);
          chk(v, a);
        end
      end
    end
  endtask

  task automatic t_bad;
    sri_word_type v, w;
    rd_var(8'h00, v);
    issue(`SRI_OP_CALC_VV, 8'h0C, 8'h00, 32'h0000_00FF, 0,
          `SRI_STATUS_BAD_TYP);
    issue(8'h27, 8'h00, 8'h00, 32'h0, 0, `SRI_STATUS_BAD_CMD);
    rd_var(8'h00, w);
    chk(w, v);
  endtask

  // A handler changes accumulator and flags, then returns back to back.
  task automatic t_return;
    set_accu(32'h0000_1111);
    enter = 1'b1;
    @(posedge core_clk);
    #1;
    enter = 1'b0;
    set_accu(32'h0000_2222);
    issue(`SRI_OP_CALC_VA, 8'h0B, 8'h00, 32'h0, 3, `SRI_STATUS_OK);
    chk(flags_out_q[1:0], 2'b10);
    issue(`SRI_OP_RETURN, 8'hFF, 8'h5A, 32'hA5A5_5A5A, 0,
          `SRI_STATUS_OK);
    chk(ctx_wr_q, 1'b1);
    chk(handler_done_q, 1'b1);
    chk(accu_out_q, 32'h0000_1111);
    chk(xreg_out_q, 32'h0000_0777);
    chk(flags_out_q, saved_flags);
    chk(pc_out_q, saved_pc);
    @(posedge core_clk);
    #1;
    chk(accu_in, 32'h0000_1111);
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_type = 8'h00;
    cmd_bank = 8'h00;
    cmd_value = 32'h0;
    set_en = 1'b0;
    set_val = 32'h0;
    enter = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_ops(`SRI_OP_CALC_VV);
    t_ops(`SRI_OP_CALC_VA);
    t_bad;
    t_return;
    stop_test;
  end

  initial begin
    #200_000;
    num_errors++;
    stop_test;
  end
endmodule
